// >>> core/desc_poll_pkg.sv
// Shared constants and carriers for the descriptor polling engine.
// Assumes a 32-bit descriptor memory port and an APB register slave.
package desc_poll_pkg;

    // ****************************************************************
    // Register map (byte offsets)
    // ****************************************************************
    localparam logic [7:0] OFS_STATUS    = 8'h00; // controller_status_register
    localparam logic [7:0] OFS_MASK      = 8'h04; // interrupt_mask_register
    localparam logic [7:0] OFS_FEATURE   = 8'h08; // feature_control_register
    localparam logic [7:0] OFS_INTERVAL  = 8'h0C; // polling_interval_register
    localparam logic [7:0] OFS_RX_BASE   = 8'h10; // Receive ring base
    localparam logic [7:0] OFS_TX_BASE   = 8'h14; // Transmit ring base
    localparam logic [7:0] OFS_RING      = 8'h18; // Ring length codes
    localparam logic [7:0] OFS_SHADOW    = 8'h1C; // Looked-ahead entry word one

    // ****************************************************************
    // Register fields
    // ****************************************************************
    localparam int BIT_INIT    = 0;  // Write 1: initialize
    localparam int BIT_RUN     = 1;  // run_bit
    localparam int BIT_STOP    = 2;  // Write 1: stop
    localparam int BIT_DEMAND  = 3;  // transmit_demand
    localparam int BIT_TX_ON   = 4;  // transmitter_running
    localparam int BIT_RX_ON   = 5;  // receiver_running
    localparam int BIT_GIE     = 6;  // global_interrupt_enable
    localparam int BIT_INITIALIZATION_DONE_FLAG   = 8;  // initialization_done_flag
    localparam int BIT_TDONE   = 9;  // transmit_done_flag, write 1 clears
    localparam int BIT_TMASK   = 9;  // transmit_done_mask
    localparam int BIT_POLLDIS = 2;  // transmit_poll_disable
    localparam int RX_CODE_LSB = 0;  // receive_ring_length_code
    localparam int TX_CODE_LSB = 8;  // Transmit ring length code
    localparam int CODE_W      = 4;

    // ****************************************************************
    // Descriptor layout
    // ****************************************************************
    localparam int D_OWN   = 31;     // Word one: owned by device
    localparam int D_ERR   = 30;     // Word one: frame error summary
    localparam int D_SOF   = 25;     // Word one: start_of_frame_flag
    localparam int D_EOF   = 24;     // Word one: end_of_frame_flag
    localparam int D_BREAK = 30;     // Word two: chain_break_error
    localparam int D_UNDERFLOW_ERROR  = 29;     // Word two: underflow_error
    localparam int LEN_W   = 16;     // Word one: buffer length
    localparam logic [31:0] W0 = 32'h0000_0000;
    localparam logic [31:0] W1 = 32'h0000_0004;
    localparam logic [31:0] W2 = 32'h0000_0008;
    localparam logic [LEN_W-1:0] WORD_BYTES = 16'h0004;

    // Default poll interval in clock periods
    localparam int POLL_DEFAULT = 65536;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic        valid;  // Access request
        logic        write;  // Direction
        logic        lock;   // Keep bus tenure for next word
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic        valid;  // One-cycle push
        logic        last;   // Final word of frame
        logic [31:0] data;
    } fifo_word_t;

    typedef enum logic [3:0] {
        S_COUNT, S_RX1, S_RX0, S_TX1, S_TX0, S_CLR, S_DATA,
        S_LOOK1, S_LOOK0, S_REL, S_WAIT, S_WB2, S_WB1
    } seq_t;

endpackage : desc_poll_pkg

// >>> core/poll_timer.sv
// Poll interval down-counter.
// Assumes reload is held while the sequencer is away from poll counting.
`timescale 1ns/10ps
module poll_timer
    import desc_poll_pkg::*;
#(
    parameter int DEFAULT = POLL_DEFAULT
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        reload,   // Restart the interval
    input  wire logic [15:0] interval, // Zero selects the default
    output logic             expired   // Interval has run out
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [16:0] cnt; // Remaining periods
    } tmr_t;

    tmr_t s;      // Registered state
    tmr_t next_s; // Next state

    if (DEFAULT < 1 || DEFAULT > 131071) begin : g_chk
        $error("poll_timer: DEFAULT out of range");
    end

    assign expired = (s.cnt == 17'h00000);

    // Reload or count one per clock
    always_comb begin
        next_s = s;
        if (reload) begin
            next_s.cnt = (interval == 16'h0000) ? 17'(DEFAULT) : {1'b0, interval};
        end else if (!expired) begin
            next_s.cnt = s.cnt - 17'h00001;
        end
    end

    // Register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : poll_timer

// >>> core/descriptor_poll_tx_lookahead.sv
// Descriptor polling and transmit lookahead sequencer.
// Assumes a one-access-per-ack memory port and a MAC giving done pulses.
// What this block does
// - Poll descriptors only while channel idle, except straight after a write-back
// - Poll disable bit stops transmit polling
// - Read word one, then zero, per tenure
// - Latch shadows; ignore unowned entry status
// - Receive poll: expiry, receiver on, ownership lacking
// - Length code zero: no next receive entry
// - Transmit poll conditions and triggers
// - Demand polls at once, receive first
// - Demand waits until poll counting resumes
// - Interval defaults to 65536, programmable
// - Unowned transmit entry: reread after expiry
// - Owned non-start entry: release, read next
// - Owned zero-length entry gets released
// - Look ahead once after first transfer
// - Unowned next in chain: error, transmitter off
// - Release first, one access, then look ahead
// - Later frame buffer may release early
// - Error: write back, skip chained entries
// - Poll immediately after every transmit
// - Set done flag; interrupt if enabled, unmasked
// - Owner flag one means device holds entry
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module descriptor_poll_tx_lookahead
    import desc_poll_pkg::*;
#(
    parameter int IDX_W     = 8,            // Ring index width
    parameter int POLL_TIME = POLL_DEFAULT  // Default interval
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output mem_req_t         mem,             // Descriptor/data access
    input  wire logic        mem_ack,         // Access completes
    input  wire logic [31:0] mem_rdata,
    input  wire logic        channel_active,  // Network busy
    input  wire logic        rx_frame_done,   // Frame just received
    input  wire logic        tx_space,        // FIFO takes a word
    input  wire logic        tx_done,         // Frame sent
    input  wire logic        tx_error,        // Frame failed
    output fifo_word_t       fifo,            // Transmit FIFO push
    output logic             irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        seq_t             st;
        logic [IDX_W-1:0] tx_idx, rx_idx;
        logic             rx_cur_own, rx_nxt_own, rx_own; // rx_own: owner bit of word one in flight
        logic [31:0]      rx_shadow;    // Owned receive word zero
        logic [31:0]      cur_w1, cur_w0, nxt_w1, nxt_w0;
        logic             look_done;    // Lookahead done this buffer
        logic             moved;        // A word of this buffer sent
        logic             fail, err;
        logic [LEN_W-1:0] rem;          // Bytes left in buffer
        logic [31:0]      ptr;          // Next data address
        logic             demand, rx_seen;
        logic             gie, tx_on, rx_on, initialization_done_flag, tdone, tmask, transmit_poll_disable;
        logic [15:0]      interval;
        logic [CODE_W-1:0] rx_code, tx_code;
        logic [31:0]      rx_base, tx_base;
        logic [31:0]      rdata;
        logic             err_resp;
        fifo_word_t       fifo;
    } st_t;

    st_t  s;       // Registered state
    st_t  next_s;  // Next state
    logic expired; // Poll interval ran out
    logic reload;  // Restart interval
    logic setup, wr;
    logic rx_need, tx_ok, trig;
    logic [IDX_W-1:0] tx_nxt, rx_nxt, rx_pick;

    if (IDX_W < 1 || IDX_W > 15) begin : g_chk
        $error("descriptor_poll_tx_lookahead: IDX_W out of range");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Ring wrap: entries = 2 ** code
    function automatic logic [IDX_W-1:0] step(logic [IDX_W-1:0] i, logic [CODE_W-1:0] c);
        logic [31:0] m;
        m = (32'h0000_0001 << c) - 32'h0000_0001;
        step = IDX_W'((32'(i) + 32'h0000_0001) & m);
    endfunction : step

    function automatic logic [31:0] ent(logic [31:0] b, logic [IDX_W-1:0] i, logic [31:0] w);
        ent = b + (32'(i) << 4) + w;
    endfunction : ent

    // Timer only runs during poll counting
    poll_timer #(.DEFAULT(POLL_TIME)) u_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .reload   (reload),
        .interval (s.interval),
        .expired  (expired)
    );

    assign reload  = (s.st != S_COUNT) || expired;
    assign pready  = 1'b1;
    assign prdata  = s.rdata;
    assign pslverr = s.err_resp;
    assign fifo    = s.fifo;
    assign irq     = s.tdone && s.gie && !s.tmask;
    assign setup   = psel && !penable;
    assign wr      = psel && penable && pwrite;
    assign tx_nxt  = step(s.tx_idx, s.tx_code);
    assign rx_nxt  = step(s.rx_idx, s.rx_code);
    // Next entry is polled only once current is owned
    assign rx_pick = s.rx_cur_own ? rx_nxt : s.rx_idx;
    // Ring of one entry has no next to check
    assign rx_need = s.rx_on && (!s.rx_cur_own || (s.rx_code != '0 && !s.rx_nxt_own));
    assign tx_ok   = s.tx_on && !s.transmit_poll_disable;
    assign trig    = expired || s.demand;

    // ****************************************************************
    // Memory request decode
    // ****************************************************************
    always_comb begin
        mem = '0;
        unique case (s.st)
            S_RX1:   mem = '{1'b1, 1'b0, 1'b1, ent(s.rx_base, rx_pick, W1), 32'h0};
            S_RX0:   mem = '{1'b1, 1'b0, 1'b0, ent(s.rx_base, rx_pick, W0), 32'h0};
            S_TX1:   mem = '{1'b1, 1'b0, 1'b1, ent(s.tx_base, s.tx_idx, W1), 32'h0};
            S_TX0:   mem = '{1'b1, 1'b0, 1'b0, ent(s.tx_base, s.tx_idx, W0), 32'h0};
            S_LOOK1: mem = '{1'b1, 1'b0, 1'b1, ent(s.tx_base, tx_nxt, W1), 32'h0};
            S_LOOK0: mem = '{1'b1, 1'b0, 1'b0, ent(s.tx_base, tx_nxt, W0), 32'h0};
            S_CLR, S_REL: begin
                // Single write handing the entry back
                mem = '{1'b1, 1'b1, 1'b0, ent(s.tx_base, s.tx_idx, W1), s.cur_w1};
                mem.wdata[D_OWN] = 1'b0;
            end
            S_WB2: begin
                mem = '{1'b1, 1'b1, 1'b1, ent(s.tx_base, s.tx_idx, W2), 32'h0};
                mem.wdata[D_BREAK] = s.fail;
                mem.wdata[D_UNDERFLOW_ERROR]  = s.fail;
            end
            S_WB1: begin
                mem = '{1'b1, 1'b1, 1'b0, ent(s.tx_base, s.tx_idx, W1), s.cur_w1};
                mem.wdata[D_OWN] = 1'b0;
                mem.wdata[D_ERR] = s.err || s.fail;
            end
            S_DATA: begin
                // Data fetch only when nothing else is due
                if (!tx_error && s.rem != '0 && !(s.moved && !s.look_done) && tx_space) begin
                    mem = '{1'b1, 1'b0, 1'b0, s.ptr, 32'h0};
                end
            end
            S_COUNT, S_WAIT: mem = '0;
        endcase
    end

    // ****************************************************************
    // Sequencer and registers
    // ****************************************************************
    always_comb begin
        next_s            = s;
        next_s.fifo.valid = 1'b0;
        next_s.fifo.last  = 1'b0;
        if (rx_frame_done) begin
            next_s.rx_seen = 1'b1;
        end
        // Software clear first so a same-cycle set survives
        if (wr && paddr == OFS_STATUS && pwdata[BIT_TDONE]) begin
            next_s.tdone = 1'b0;
        end
        unique case (s.st)
            S_COUNT: begin
                // Demand is only seen here, so a late one waits
                if (!channel_active && ((tx_ok && (trig || s.rx_seen)) || (rx_need && trig))) begin
                    next_s.st      = (rx_need && trig) ? S_RX1 : S_TX1;
                    next_s.demand  = 1'b0;
                    next_s.rx_seen = 1'b0;
                end
            end
            S_RX1: if (mem_ack) begin
                // Ownership applied after word zero, so both words come from one entry
                next_s.rx_own = mem_rdata[D_OWN];
                next_s.st     = S_RX0;
            end
            S_RX0: if (mem_ack) begin
                next_s.rx_cur_own = s.rx_cur_own || s.rx_own;
                next_s.rx_nxt_own = s.rx_cur_own ? s.rx_own : s.rx_nxt_own;
                next_s.rx_shadow  = s.rx_own ? mem_rdata : s.rx_shadow;
                next_s.st         = tx_ok ? S_TX1 : S_COUNT;
            end
            S_TX1: if (mem_ack) begin
                next_s.cur_w1 = mem_rdata;
                next_s.st     = S_TX0;
            end
            S_TX0: if (mem_ack) begin
                next_s.cur_w0 = mem_rdata;
                if (!s.cur_w1[D_OWN]) begin
                    next_s.st = S_COUNT;
                end else if (!s.cur_w1[D_SOF] || s.cur_w1[LEN_W-1:0] == '0) begin
                    next_s.st = S_CLR;
                end else begin
                    next_s.st        = S_DATA;
                    next_s.rem       = s.cur_w1[LEN_W-1:0];
                    next_s.ptr       = mem_rdata;
                    next_s.look_done = 1'b0;
                    next_s.moved     = 1'b0;
                    next_s.fail      = 1'b0;
                    next_s.err       = 1'b0;
                end
            end
            S_CLR: if (mem_ack) begin
                next_s.tx_idx = tx_nxt;
                next_s.st     = S_TX1;
            end
            S_DATA: begin
                if (tx_error) begin
                    next_s.err = 1'b1;
                    next_s.st  = S_WB2;
                end else if (s.rem == '0) begin
                    if (!s.look_done) begin
                        next_s.st = S_LOOK1;
                    end else if (s.cur_w1[D_EOF]) begin
                        next_s.st = S_WAIT;
                    end else if (s.nxt_w1[D_OWN]) begin
                        next_s.st = S_REL;
                    end else begin
                        next_s.fail = 1'b1;
                        next_s.st   = S_WAIT;
                    end
                end else if (s.moved && !s.look_done) begin
                    next_s.st = S_LOOK1;
                end else if (mem_ack && mem.valid) begin
                    next_s.fifo.valid = 1'b1;
                    next_s.fifo.data  = mem_rdata;
                    next_s.fifo.last  = s.cur_w1[D_EOF] && s.rem <= WORD_BYTES;
                    next_s.ptr        = s.ptr + 32'h0000_0004;
                    next_s.rem        = (s.rem <= WORD_BYTES) ? '0 : s.rem - WORD_BYTES;
                    next_s.moved      = 1'b1;
                end
            end
            S_LOOK1: if (mem_ack) begin
                next_s.nxt_w1 = mem_rdata;
                next_s.st     = S_LOOK0;
            end
            S_LOOK0: if (mem_ack) begin
                next_s.nxt_w0    = mem_rdata;
                next_s.look_done = 1'b1;
                next_s.st        = S_DATA;
            end
            S_REL: if (mem_ack) begin
                // Continue on the next chained buffer
                next_s.cur_w1    = s.nxt_w1;
                next_s.cur_w0    = s.nxt_w0;
                next_s.tx_idx    = tx_nxt;
                next_s.rem       = s.nxt_w1[LEN_W-1:0];
                next_s.ptr       = s.nxt_w0;
                next_s.look_done = 1'b0;
                next_s.moved     = 1'b0;
                next_s.st        = S_DATA;
            end
            S_WAIT: begin
                if (tx_error) begin
                    next_s.err = 1'b1;
                    next_s.st  = S_WB2;
                end else if (tx_done) begin
                    next_s.st = S_WB2;
                end
            end
            S_WB2: if (mem_ack) next_s.st = S_WB1;
            S_WB1: if (mem_ack) begin
                next_s.tdone  = 1'b1;
                next_s.tx_idx = tx_nxt;
                if (s.fail) begin
                    next_s.tx_on = 1'b0;
                    next_s.st    = rx_need ? S_RX1 : S_COUNT;
                end else begin
                    next_s.st = rx_need ? S_RX1 : (tx_ok ? S_TX1 : S_COUNT);
                end
            end
        endcase
        // Register writes, after the sequencer so software wins control
        if (wr) begin
            unique case (paddr)
                OFS_STATUS: begin
                    next_s.gie = pwdata[BIT_GIE];
                    if (pwdata[BIT_DEMAND]) begin
                        next_s.demand = 1'b1;
                    end
                    if (pwdata[BIT_INIT] || pwdata[BIT_STOP] || pwdata[BIT_RUN]) begin
                        // Restart from ring bases with no ownership known
                        next_s.st         = S_COUNT;
                        next_s.tx_idx     = '0;
                        next_s.rx_idx     = '0;
                        next_s.rx_cur_own = 1'b0;
                        next_s.rx_nxt_own = 1'b0;
                        next_s.tx_on      = pwdata[BIT_RUN] && !pwdata[BIT_STOP];
                        next_s.rx_on      = pwdata[BIT_RUN] && !pwdata[BIT_STOP];
                        next_s.initialization_done_flag      = pwdata[BIT_INIT] && !pwdata[BIT_STOP];
                    end
                end
                OFS_MASK:    next_s.tmask = pwdata[BIT_TMASK];
                OFS_FEATURE: next_s.transmit_poll_disable = pwdata[BIT_POLLDIS];
                OFS_INTERVAL: begin
                    // Taken only after init is done and before running
                    if (s.initialization_done_flag && !s.tx_on && !s.rx_on) begin
                        next_s.interval = pwdata[15:0];
                    end
                end
                OFS_RX_BASE: next_s.rx_base = pwdata;
                OFS_TX_BASE: next_s.tx_base = pwdata;
                OFS_RING: begin
                    next_s.rx_code = pwdata[RX_CODE_LSB +: CODE_W];
                    next_s.tx_code = pwdata[TX_CODE_LSB +: CODE_W];
                end
                default: next_s.rdata = s.rdata;
            endcase
        end
        // Read data and error captured in setup, held through access
        if (setup) begin
            next_s.err_resp = 1'b0;
            next_s.rdata    = 32'h0000_0000;
            unique case (paddr)
                OFS_STATUS: begin
                    next_s.rdata[BIT_DEMAND] = s.demand;
                    next_s.rdata[BIT_TX_ON]  = s.tx_on;
                    next_s.rdata[BIT_RX_ON]  = s.rx_on;
                    next_s.rdata[BIT_GIE]    = s.gie;
                    next_s.rdata[BIT_INITIALIZATION_DONE_FLAG]  = s.initialization_done_flag;
                    next_s.rdata[BIT_TDONE]  = s.tdone;
                end
                OFS_MASK:     next_s.rdata[BIT_TMASK] = s.tmask;
                OFS_FEATURE:  next_s.rdata[BIT_POLLDIS] = s.transmit_poll_disable;
                OFS_INTERVAL: next_s.rdata[15:0] = s.interval;
                OFS_RX_BASE:  next_s.rdata = s.rx_base;
                OFS_TX_BASE:  next_s.rdata = s.tx_base;
                OFS_RING: begin
                    next_s.rdata[RX_CODE_LSB +: CODE_W] = s.rx_code;
                    next_s.rdata[TX_CODE_LSB +: CODE_W] = s.tx_code;
                end
                OFS_SHADOW:   next_s.rdata = s.nxt_w1;
                default:      next_s.err_resp = 1'b1;
            endcase
        end
    end

    // Register the whole state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s    <= '0;
            s.st <= S_COUNT;
        end else begin
            s <= next_s;
        end
    end

endmodule : descriptor_poll_tx_lookahead

// >>> bench/desc_poll_props.sv
// Port checker for the descriptor poller.
// Assumes it is bound onto the top module.
`timescale 1ns/10ps
module desc_poll_props
    import desc_poll_pkg::*;
(
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ack,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire mem_req_t    mem,
    input wire fifo_word_t  fifo
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_high_a: assert property (pready) else $error("pready low");
    reset_quiet_a: assert property ($rose(presetn) |-> !mem.valid && !fifo.valid) else $error("busy after reset");
    mem_hold_a: assert property (mem.valid && !mem_ack |=> mem.valid && $stable(mem)) else $error("request moved");
    tenure_order_a: assert property (mem.valid && mem.lock && mem_ack |=> mem.addr == $past(mem.addr) - W1)
        else $error("tenure order");
    own_release_a: assert property (mem.valid && mem.write && mem.addr[3:0] == 4'h4 |-> !mem.wdata[D_OWN])
        else $error("owner kept");
    bad_addr_a: assert property (psel && !penable && !pwrite && paddr > OFS_SHADOW |=> pslverr && prdata == 32'h0)
        else $error("unmapped read");
    good_addr_a: assert property (psel && !penable && paddr <= OFS_SHADOW && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped error");
    fifo_cause_a: assert property (fifo.valid |-> $past(mem_ack) && !$past(mem.write)) else $error("push cause");
endmodule : desc_poll_props
bind descriptor_poll_tx_lookahead desc_poll_props chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
    .pslverr, .mem_ack, .paddr, .prdata, .mem, .fifo);

// >>> bench/host_mem.sv
// Host memory model behind the memory port.
// Assumes the bench preloads the word store.
`timescale 1ns/10ps
module host_mem
    import desc_poll_pkg::*;
(
    input  wire logic     pclk,
    input  wire mem_req_t mem,
    output logic          mem_ack = 1'b0,
    output logic [31:0]   mem_rdata = 32'h0
);
    logic [31:0] m [0:255]; // Word store, address bits 9:2
    int          stall = 0; // Random delay before answer
    // Data lines churn while idle
    always @(posedge pclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem.valid && !mem_ack) begin
            if (stall > 0) stall <= stall - 1;
            else begin
                mem_ack <= 1'b1;
                stall <= $urandom_range(2);
                mem_rdata <= m[mem.addr[9:2]];
                if (mem.write) m[mem.addr[9:2]] <= mem.wdata;
            end
        end
    end
endmodule : host_mem

// >>> bench/tb_descriptor_poll_tx_lookahead.sv
// Self-checking bench for the descriptor poller.
// Assumes host_mem and the bound checker.
`timescale 1ns/10ps
module tb_descriptor_poll_tx_lookahead
    import desc_poll_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tx_done = 0, mem_ack, pready, pslverr, irq;
    logic        tx_error = 0, ql[$] = '{1'b0, 1'b1, 1'b1}; // ql: expected end-of-frame marks
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, mem_rdata, d0, qa[$], qf[$];
    mem_req_t    mem;
    fifo_word_t  fifo;
    int          fails = 0, checked = 0, cyc = 0;
    always #25 pclk = ~pclk;
    descriptor_poll_tx_lookahead #(.POLL_TIME(16)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .mem, .mem_ack, .mem_rdata, .channel_active(1'b0),
        .rx_frame_done(1'b0), .tx_space(1'b1), .tx_done, .tx_error, .fifo, .irq);
    host_mem host (.pclk, .mem, .mem_ack, .mem_rdata);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e = 0);
        if (!w) qa.push_back(e);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : apb
    always @(posedge pclk) if (++cyc == 20000) begin
        fails++;
        wrap_up();
    end
    // Oldest note against each result
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) chk("prdata", qa.size() ? qa.pop_front() : 32'hBAD, prdata);
        if (fifo.valid === 1'b1) chk("fifo", qf.size() ? qf.pop_front() : 32'hBAD, fifo.data);
        if (fifo.valid === 1'b1) chk("last", ql.size() ? ql.pop_front() : 32'hBAD, fifo.last);
    end
    initial begin
        d0 = $urandom(98);
        foreach (host.m[i]) host.m[i] = $urandom_range(1) ? 32'h0 : 32'h0;
        host.m[8'h40] = 32'h0300;
        host.m[8'h41] = 32'h8300_0008;
        host.m[8'h45] = 32'h8000_0004;
        host.m[8'h49] = 32'h8200_0000;
        host.m[8'h4C] = 32'h0300;
        host.m[8'hC0] = $urandom;
        host.m[8'hC1] = $urandom;
        qf = '{host.m[8'hC0], host.m[8'hC1], host.m[8'hC0]};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_STATUS, 0, 32'h0);
        apb(0, 8'h20, 0, 32'h0);
        apb(1, OFS_TX_BASE, 32'h100);
        apb(1, OFS_RX_BASE, 32'h200);
        apb(1, OFS_RING, 32'h200);
        apb(1, OFS_STATUS, 32'h1);
        apb(0, OFS_STATUS, 0, 32'h100);
        apb(1, OFS_INTERVAL, 32'h14);
        apb(1, OFS_STATUS, 32'h42);
        for (int k = 0; k < 3000 && qf.size() > 1; k++) @(posedge pclk);
        tx_done <= 1'b1;
        for (int k = 0; k < 500 && (mem.valid !== 1'b1 || mem.write !== 1'b1); k++) @(posedge pclk);
        tx_done <= 1'b0;
        for (int k = 0; k < 3000 && host.m[8'h49][31] !== 1'b0; k++) @(posedge pclk);
        chk("own0", 32'h0, host.m[8'h41] & 32'h8000_0000);
        chk("own1", 32'h0, host.m[8'h45] & 32'h8000_0000);
        chk("own2", 32'h0, host.m[8'h49] & 32'h8000_0000);
        @(negedge pclk) chk("irq", 32'h1, irq);
        apb(1, OFS_MASK, 32'h200);
        @(negedge pclk) chk("masked", 32'h0, irq);
        apb(1, OFS_FEATURE, 32'h4);
        repeat (30) @(posedge pclk); // Let a poll already under way finish first
        host.m[8'h4D] = 32'h8300_0004;
        repeat (100) @(posedge pclk);
        chk("own3", 32'h8000_0000, host.m[8'h4D] & 32'h8000_0000);
        chk("held", 32'h1, qf.size());
        apb(1, OFS_FEATURE, 32'h0);
        for (int k = 0; k < 3000 && qf.size() > 0; k++) @(posedge pclk);
        chk("queue", 32'h0, qf.size());
        // Error held until the write-back starts, lookahead reads ignore it
        tx_error <= 1'b1;
        for (int k = 0; k < 500 && (mem.valid !== 1'b1 || mem.write !== 1'b1); k++) @(posedge pclk);
        tx_error <= 1'b0;
        for (int k = 0; k < 300 && host.m[8'h4D][31] !== 1'b0; k++) @(posedge pclk);
        chk("errwb", 32'h4300_0004, host.m[8'h4D]);
        wrap_up();
    end
endmodule : tb_descriptor_poll_tx_lookahead
